// [design/acc_pkg.sv]
// Purpose: shared constants and types for the comparator control block
// Assumes: Avalon-MM slave with 32-bit data, word addressing by byte address
// Notes: register offsets are byte addresses
package acc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
  localparam int BIT_ENABLE = 15;
  localparam int BIT_PIN_EN = 14;
  localparam int BIT_INVERT = 13;
  localparam int BIT_RESULT = 8;
  localparam int BIT_EDGE_HI = 7;
  localparam int BIT_EDGE_LO = 6;
  localparam int BIT_POS_SEL = 4;
  localparam int BIT_NEG_HI = 1;
  localparam int BIT_NEG_LO = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0000E0D3;
  localparam logic [7:0] CTRL_RESET_LO = 8'hC3;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] NEG_EXT_B = 2'h0;
  localparam logic [1:0] NEG_EXT_C = 2'h1;
  localparam logic [1:0] NEG_EXT_D = 2'h2;
  localparam logic [1:0] NEG_BANDGAP = 2'h3;
  localparam logic [1:0] STAT_EVENT = 2'h1;
  localparam logic [1:0] STAT_RESET = 2'h0;
  typedef struct packed {
    logic enable;
    logic pin_en;
    logic invert;
    logic [1:0] edge_sel;
    logic pos_sel;
    logic [1:0] neg_sel;
  } acc_ctrl_type;
  typedef struct packed {
    logic analog_enable;
    logic positive_input_select;
    logic [1:0] negative_input_select;
  } acc_analog_type;
endpackage

// [design/acc_top.sv]
// Purpose: control, status and event logic around one analog comparator
// Assumes: comparator output is asynchronous; bus is Avalon-MM with waitrequest
// Notes: one clock, synchronous active-low reset
// What this block does
// - bit 15 turns comparator on; toggling it leaves other fields alone.
// - bit 14 set drives the result onto the result pin.
// - bit 13 set inverts the comparator output.
// - read-only bit 8 shows the current comparator result.
// - bits 7-6 pick event edges: off, rising, falling, both.
// - inversion also feeds the edge detector, flipping the selected edge.
// - bit 4 picks reference voltage or external input a as positive input.
// - bits 1-0 pick inputs b, c, d or bandgap as negative input.
// - unimplemented bits read zero and ignore writes.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [acc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic comparator_raw,
  output acc_pkg::acc_analog_type analog_ctrl,
  output logic result_pin_out,
  output logic result_pin_oe,
  output logic event_pulse,
  output logic irq
);
  import acc_pkg::*;

  acc_ctrl_type ctrl_q;
  logic sync1_q;
  logic sync2_q;
  logic result_q;
  logic result_prev_q;
  logic event_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic access;
  logic [31:0] be_mask;
  logic [31:0] ctrl_word;
  logic result_inv;
  logic rise;
  logic fall;
  logic hit;
  logic wr_fire;
  logic [31:0] ctrl_next;
  logic [1:0] stat_clr;

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    return (a == OFS_CONTROL) || (a == OFS_STATUS) || (a == OFS_MASK);
  endfunction

  assign access = (avs_read || avs_write) && !ack_q;
  // a write lands only at the edge where waitrequest is low
  assign wr_fire = avs_write && ack_q;
  assign ctrl_next = (ctrl_word & ~(be_mask & CTRL_WMASK)) | (avs_writedata & be_mask & CTRL_WMASK);
  assign stat_clr = (wr_fire && avs_address == OFS_STATUS && avs_byteenable[0]) ?
                    avs_writedata[1:0] : 2'h0;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // control word image
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[BIT_ENABLE] = ctrl_q.enable;
    ctrl_word[BIT_PIN_EN] = ctrl_q.pin_en;
    ctrl_word[BIT_INVERT] = ctrl_q.invert;
    ctrl_word[BIT_RESULT] = result_inv;
    ctrl_word[BIT_EDGE_HI:BIT_EDGE_LO] = ctrl_q.edge_sel;
    ctrl_word[BIT_POS_SEL] = ctrl_q.pos_sel;
    ctrl_word[BIT_NEG_HI:BIT_NEG_LO] = ctrl_q.neg_sel;
  end

  // control register writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= '{enable: 1'b0, pin_en: 1'b0, invert: 1'b0,
                  edge_sel: CTRL_RESET_LO[7:6], pos_sel: CTRL_RESET_LO[4],
                  neg_sel: CTRL_RESET_LO[1:0]};
    end else if (wr_fire && avs_address == OFS_CONTROL) begin
      ctrl_q.enable <= ctrl_next[BIT_ENABLE];
      ctrl_q.pin_en <= ctrl_next[BIT_PIN_EN];
      ctrl_q.invert <= ctrl_next[BIT_INVERT];
      ctrl_q.edge_sel <= ctrl_next[BIT_EDGE_HI:BIT_EDGE_LO];
      ctrl_q.pos_sel <= ctrl_next[BIT_POS_SEL];
      ctrl_q.neg_sel <= ctrl_next[BIT_NEG_HI:BIT_NEG_LO];
    end
  end

  // input synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= comparator_raw;
      sync2_q <= sync1_q;
    end
  end

  assign result_inv = sync2_q ^ ctrl_q.invert;

  // result and edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_q <= 1'b0;
      result_prev_q <= 1'b0;
    end else begin
      // history tracks the input while off, so enabling gives no false edge
      result_q <= result_inv;
      result_prev_q <= ctrl_q.enable ? result_q : result_inv;
    end
  end

  assign rise = result_q && !result_prev_q;
  assign fall = !result_q && result_prev_q;

  always_comb begin
    case (ctrl_q.edge_sel)
      EDGE_OFF: hit = 1'b0;
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
  end

  // event pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      event_q <= 1'b0;
    end else begin
      event_q <= hit && ctrl_q.enable;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= STAT_RESET;
    end else begin
      status_q <= (status_q & ~stat_clr) | (event_q ? STAT_EVENT : 2'h0);
    end
  end

  // mask register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= 2'h0;
    end else if (wr_fire && avs_address == OFS_MASK && avs_byteenable[0]) begin
      mask_q <= avs_writedata[1:0] & STAT_EVENT;
    end
  end

  // bus answer one cycle after request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      resp_q <= 2'h0;
    end else begin
      ack_q <= access;
      if (access) begin
        resp_q <= known_addr(avs_address) ? 2'h0 : 2'h2;
        rdata_q <= 32'h00000000;
        if (avs_read) begin
          case (avs_address)
            OFS_CONTROL: rdata_q <= ctrl_word;
            OFS_STATUS: rdata_q <= {30'h00000000, status_q};
            OFS_MASK: rdata_q <= {30'h00000000, mask_q};
            default: rdata_q <= 32'h00000000;
          endcase
        end
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;

  // pin and analog outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_pin_out <= 1'b0;
      result_pin_oe <= 1'b0;
    end else begin
      result_pin_out <= result_inv && ctrl_q.enable;
      result_pin_oe <= ctrl_q.pin_en;
    end
  end

  assign analog_ctrl.analog_enable = ctrl_q.enable;
  assign analog_ctrl.positive_input_select = ctrl_q.pos_sel;
  assign analog_ctrl.negative_input_select = ctrl_q.neg_sel;
  assign event_pulse = event_q;
  assign irq = |(status_q & mask_q);
endmodule // acc_top
`default_nettype wire

// [testbench/acc_cmp_model.sv]
// Purpose: comparator core stand-in
// Assumes: level is the analog decision
// Notes: output low while off
`timescale 1ns/10ps
`default_nettype none
module acc_cmp_model (
  input wire acc_pkg::acc_analog_type ctrl,
  input wire logic level,
  output logic raw
);
  import acc_pkg::*;
  assign raw = ctrl.analog_enable & level;
endmodule // acc_cmp_model
`default_nettype wire

// [testbench/acc_asserts.sv]
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module acc_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [acc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire acc_pkg::acc_analog_type analog_ctrl,
  input wire logic result_pin_out,
  input wire logic result_pin_oe,
  input wire logic event_pulse,
  input wire logic irq
);
  import acc_pkg::*;
  wire logic cw = avs_write && avs_waitrequest && avs_address == OFS_CONTROL;
  wire logic cr = avs_read && avs_waitrequest;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property (cr | cw |=> !avs_waitrequest) else $error("no answer");
  ctl_ana_a: assert property (cw |-> ##2 analog_ctrl == $past({avs_writedata[15],
    avs_writedata[4], avs_writedata[1:0]}, 2)) else $error("bad analog");
  pin_oe_a: assert property (cw |-> ##3 result_pin_oe == $past(avs_writedata[14], 3))
    else $error("bad oe");
  pin_off_a: assert property (!analog_ctrl.analog_enable |=> !result_pin_out)
    else $error("pin on");
  evt_off_a: assert property (event_pulse |-> analog_ctrl.analog_enable
    || $past(analog_ctrl.analog_enable)) else $error("event off");
  bad_adr_a: assert property (cr && avs_address == 4'hC |=> avs_response == 2'h2)
    else $error("bad resp");
  rsv_zero_a: assert property (cr && avs_address == OFS_CONTROL |=>
    (avs_readdata & 32'hFFFF1E2C) == 32'h0) else $error("rsv bits");
  rst_val_a: assert property ($rose(rst_n) |-> analog_ctrl == 4'h3 && !irq)
    else $error("reset");
  c_evt: cover property (event_pulse);
  c_irq: cover property (irq);
  c_wr: cover property (cw);
endmodule // acc_asserts
bind acc_top acc_asserts u_chk (.*);
`default_nettype wire

// [testbench/acc_top_tb_top.sv]
// Purpose: register and event tests
// Assumes: one wait cycle per access
// Notes: byte lanes all on
`timescale 1ns/10ps
`default_nettype none
module acc_top_tb_top;
  import acc_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [ADDR_W-1:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, comparator_raw, result_pin_out, result_pin_oe, event_pulse, irq;
  logic [1:0] avs_response;
  acc_analog_type analog_ctrl;
  logic level = 1'h0;
  int errors = 0;
  int n_compared = 0;
  acc_top u_dut (.*);
  acc_cmp_model u_cmp (.ctrl(analog_ctrl), .level(level), .raw(comparator_raw));
  always #10 sys_clk = ~sys_clk;
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'h0);
    rdat = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    bus(1'h0, OFS_CONTROL, 32'h0);
    chk(rdat, 32'h000000C3);
    bus(1'h1, OFS_CONTROL, 32'hFFFFFFFF);
    repeat (4) @(posedge sys_clk);
    bus(1'h0, OFS_CONTROL, 32'h0);
    chk(rdat, 32'h0000E1D3);
    chk({28'h0, analog_ctrl}, 32'hF);
    chk({31'h0, result_pin_oe}, 32'h1);
    chk({31'h0, result_pin_out}, 32'h1);
    $display("t1 end");
    bus(1'h1, OFS_MASK, 32'h1);
    for (int m = 0; m < 8; m++) begin
      bus(1'h1, OFS_CONTROL, {16'h0, 1'h1, 1'h0, m[2], 5'h0, m[1:0], 6'h0});
      repeat (8) @(posedge sys_clk);
      bus(1'h1, OFS_STATUS, 32'h1);
      level <= 1'h1;
      repeat (8) @(posedge sys_clk);
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rdat, {31'h0, m[2] ? m[1] : m[0]});
      chk({31'h0, irq}, {31'h0, m[2] ? m[1] : m[0]});
      bus(1'h1, OFS_STATUS, 32'h1);
      level <= 1'h0;
      repeat (8) @(posedge sys_clk);
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rdat, {31'h0, m[2] ? m[0] : m[1]});
    end
    bus(1'h1, OFS_STATUS, 32'h1);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    $display("t2 end");
    bus(1'h1, OFS_MASK, 32'h0);
    level <= 1'h1;
    repeat (8) @(posedge sys_clk);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'h1, OFS_STATUS, 32'h1);
    bus(1'h1, OFS_CONTROL, 32'h000000C0);
    @(posedge sys_clk);
    level <= 1'h0;
    repeat (8) @(posedge sys_clk);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, result_pin_out}, 32'h0);
    bus(1'h0, 4'hC, 32'h0);
    chk(rdat, 32'h0);
    chk({30'h0, avs_response}, 32'h2);
    $display("t3 end");
    give_verdict;
  end
endmodule // acc_top_tb_top
`default_nettype wire
